// ### rtl/tcir_pkg.sv
// Package for the tape channel input read-back block
// Assumes doc bit n of a bus word is vector index 15-n (bit 0 is MSB)
package tcir_pkg;

  // Input function codes
  localparam logic [5:0] TCIR_FC_RANGE    = 6'h0C;
  localparam logic [5:0] TCIR_FC_ADDR     = 6'h08;
  localparam logic [5:0] TCIR_FC_CFG_A    = 6'h10;
  localparam logic [5:0] TCIR_FC_CFG_B    = 6'h12;
  localparam logic [5:0] TCIR_FC_INT_LVL  = 6'h02;
  localparam logic [5:0] TCIR_FC_DEV_ID   = 6'h26;
  localparam logic [5:0] TCIR_FC_TASK     = 6'h06;
  localparam logic [5:0] TCIR_FC_STATUS1  = 6'h18;

  // Output function codes
  localparam logic [5:0] TCIR_FC_OUT_INT  = 6'h03;
  localparam logic [5:0] TCIR_FC_OUT_CFGA = 6'h11;
  localparam logic [5:0] TCIR_FC_OUT_CFGB = 6'h13;

  // Word field positions as vector indices
  localparam int TCIR_SW1_READY    = 15;
  localparam int TCIR_SW1_ATTN     = 14;
  localparam int TCIR_SW1_BOT      = 9;
  localparam int TCIR_SW1_UNEQUAL  = 7;
  localparam int TCIR_CFGB_BAI     = 11;
  localparam int TCIR_CFGB_FRST    = 10;
  localparam int TCIR_CFGB_FRDY    = 9;
  localparam int TCIR_ID_TRACK     = 5;

  // Identification field values
  localparam logic [7:0] TCIR_ID_SUBSYS   = 8'h5A; // Arbitrary value
  localparam logic [1:0] TCIR_ID_CTL_FMT  = 2'h1;
  localparam logic [2:0] TCIR_ID_DENSITY  = 3'h6;
  localparam logic [1:0] TCIR_ID_SPEED    = 2'h3;

  // Reset values
  localparam logic [15:0] TCIR_WORD_RST   = 16'h0000;
  localparam logic [5:0]  TCIR_LEVEL_RST  = 6'h00;

  typedef enum {TCIR_IDLE, TCIR_RESP} tcir_state_e;

endpackage

// ### rtl/tcir_sync_if.sv
// Interface between the block and its pin synchroniser
// Assumes both ends run on clk_sys
`timescale 1ns/1ps
`default_nettype none
interface tcir_sync_if #(parameter int W = 5);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport sync_end (input raw, output synced);
  modport user_end (output raw, input synced);
endinterface
`default_nettype wire

// ### rtl/tcir_sync.sv
// Two-flop synchroniser for drive and formatter status pins
// Assumes pins are asynchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module tcir_sync #(
  parameter int W = 5
) (
  input  wire logic      clk_sys,
  input  wire logic      rst_n,
  tcir_sync_if.sync_end  pins
);
  logic [W-1:0] stage1;
  logic [W-1:0] stage2;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= pins.raw;
      stage2 <= stage1;
    end
  end

  assign pins.synced = stage2;
endmodule
`default_nettype wire

// ### rtl/tcir_top.sv
// Tape channel input read-back: answers input commands per function code
// Assumes bus request signals are synchronous to clk_sys; drive pins are not
//
// Functional notes
// (RULE1) Code 0C returns the range register
// (RULE2) Response echoes request data on address
// (RULE3) Nonzero residual plus unequal flag: block shorter
// (RULE4) Zero residual plus unequal flag: block longer
// (RULE5) Zero residual, flag clear: exact length
// (RULE6) Code 08 returns low address sixteen bits
// (RULE7) Write ending on high byte reports next word
// (RULE8) Code 10 returns configuration word A
// (RULE9) Code 12 returns configuration word B
// (RULE10) Code 02 puts level on bits 10-15
// (RULE11) Level is last written, zero after initialize
// (RULE12) Level response bits 0-9 carry channel number
// (RULE13) Code 26 returns identification, subsystem code
// (RULE14) Identification bits 8-9 controller type 01
// (RULE15) Identification bit 10 track count
// (RULE16) Identification bits 11-13 density flags
// (RULE17) Identification bits 14-15 speed code 11
// (RULE18) Code 06 returns last operation task word
// (RULE19) Code 18 returns status word 1
// (RULE20) Ready only when online, loaded, not rewinding
// (RULE21) Initialize resets channel, level to zero
// (RULE22) Reserved bits read as zero
`timescale 1ns/1ps
`default_nettype none
module tcir_top
  import tcir_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        bus_init,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [5:0]  cmd_func,
  input  wire logic [15:0] cmd_data,
  input  wire logic [9:0]  chan_num,
  input  wire logic        eng_range_load,
  input  wire logic [15:0] eng_range_value,
  input  wire logic        eng_read_done,
  input  wire logic [15:0] eng_block_len,
  input  wire logic        eng_addr_load,
  input  wire logic [15:0] eng_addr_value,
  input  wire logic        eng_write_done,
  input  wire logic        eng_task_load,
  input  wire logic [15:0] eng_task_value,
  input  wire logic        pin_online,
  input  wire logic        pin_loaded,
  input  wire logic        pin_rewinding,
  input  wire logic        pin_bot,
  input  wire logic        pin_formatter_ready,
  input  wire logic        pin_seven_track,
  output logic             rsp_valid,
  output logic             rsp_nak,
  output logic [15:0]      rsp_data,
  output logic [15:0]      rsp_addr,
  output logic             formatter_reset,
  output logic             bus_address_inhibit
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  tcir_sync_if #(.W(6)) pins_if ();

  assign pins_if.raw = {pin_online, pin_loaded, pin_rewinding,
                        pin_bot, pin_formatter_ready, pin_seven_track};

  tcir_sync #(.W(6)) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pins    (pins_if)
  );

  logic online_s;
  logic loaded_s;
  logic rewinding_s;
  logic bot_s;
  logic frdy_s;
  logic seven_s;

  assign online_s    = pins_if.synced[5];
  assign loaded_s    = pins_if.synced[4];
  assign rewinding_s = pins_if.synced[3];
  assign bot_s       = pins_if.synced[2];
  assign frdy_s      = pins_if.synced[1];
  assign seven_s     = pins_if.synced[0];

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  logic in_cmd;
  logic out_cmd;

  assign in_cmd  = cmd_valid && !cmd_write;
  assign out_cmd = cmd_valid && cmd_write;

  ////////////////////////////////////////////////////////////////////////////
  // Range register and unequal-length flag
  logic [15:0] range_reg;
  logic        unequal;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      range_reg <= TCIR_WORD_RST;
      unequal   <= 1'b0;
    end else if (bus_init) begin
      range_reg <= TCIR_WORD_RST;                     // see (RULE21)
      unequal   <= 1'b0;
    end else if (eng_range_load) begin
      range_reg <= eng_range_value;
      unequal   <= 1'b0;
    end else if (eng_read_done) begin
      if (eng_block_len < range_reg) begin
        range_reg <= range_reg - eng_block_len;       // see (RULE3)
        unequal   <= 1'b1;
      end else if (eng_block_len > range_reg) begin
        range_reg <= TCIR_WORD_RST;                   // see (RULE4)
        unequal   <= 1'b1;
      end else begin
        range_reg <= TCIR_WORD_RST;                   // see (RULE5)
        unequal   <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory byte address
  logic [15:0] mem_addr;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr <= TCIR_WORD_RST;
    end else if (bus_init) begin
      mem_addr <= TCIR_WORD_RST;                      // see (RULE21)
    end else if (eng_write_done && eng_addr_value[0]) begin
      mem_addr <= eng_addr_value + 16'h0001;          // see (RULE7)
    end else if (eng_addr_load || eng_write_done) begin
      mem_addr <= eng_addr_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration words
  logic [15:0] cfg_a;
  logic        cfg_bai;
  logic        cfg_frst;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_a <= TCIR_WORD_RST;
    end else if (bus_init) begin
      cfg_a <= TCIR_WORD_RST;
    end else if (out_cmd && cmd_func == TCIR_FC_OUT_CFGA) begin
      cfg_a <= cmd_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_bai  <= 1'b0;
      cfg_frst <= 1'b0;
    end else if (bus_init) begin
      cfg_bai  <= 1'b0;
      cfg_frst <= 1'b0;
    end else if (out_cmd && cmd_func == TCIR_FC_OUT_CFGB) begin
      cfg_bai  <= cmd_data[TCIR_CFGB_BAI];
      cfg_frst <= cmd_data[TCIR_CFGB_FRST];
    end
  end

  assign formatter_reset     = cfg_frst;
  assign bus_address_inhibit = cfg_bai;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt level
  logic [5:0] int_level;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      int_level <= TCIR_LEVEL_RST;
    end else if (bus_init) begin
      int_level <= TCIR_LEVEL_RST;                    // see (RULE21)
    end else if (out_cmd && cmd_func == TCIR_FC_OUT_INT) begin
      int_level <= cmd_data[5:0];                     // see (RULE11)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Task word
  logic [15:0] task_word;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      task_word <= TCIR_WORD_RST;
    end else if (bus_init) begin
      task_word <= TCIR_WORD_RST;                     // see (RULE18)
    end else if (eng_task_load) begin
      task_word <= eng_task_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Device ready and attention
  logic dev_ready;
  logic ready_q;
  logic attention;
  logic ready_chg;
  logic sw1_read;

  assign dev_ready = online_s && loaded_s && !rewinding_s;  // see (RULE20)
  assign ready_chg = dev_ready != ready_q;
  assign sw1_read  = in_cmd && cmd_func == TCIR_FC_STATUS1;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= dev_ready;
    end
  end

  // Set wins over clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      attention <= 1'b0;
    end else if (ready_chg) begin
      attention <= 1'b1;
    end else if (bus_init || sw1_read) begin
      attention <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-back words
  logic [15:0] status1_word;
  logic [15:0] cfg_b_word;
  logic [15:0] id_word;
  logic [15:0] level_word;

  always_comb begin
    status1_word                   = TCIR_WORD_RST;   // see (RULE22)
    status1_word[TCIR_SW1_READY]   = dev_ready;       // see (RULE20)
    status1_word[TCIR_SW1_ATTN]    = attention;
    status1_word[TCIR_SW1_BOT]     = bot_s;
    status1_word[TCIR_SW1_UNEQUAL] = unequal;         // see (RULE3)
  end

  always_comb begin
    cfg_b_word                 = TCIR_WORD_RST;       // see (RULE22)
    cfg_b_word[TCIR_CFGB_BAI]  = cfg_bai;             // see (RULE9)
    cfg_b_word[TCIR_CFGB_FRST] = cfg_frst;
    cfg_b_word[TCIR_CFGB_FRDY] = frdy_s;
  end

  always_comb begin
    id_word                = TCIR_WORD_RST;
    id_word[15:8]          = TCIR_ID_SUBSYS;          // see (RULE13)
    id_word[7:6]           = TCIR_ID_CTL_FMT;         // see (RULE14)
    id_word[TCIR_ID_TRACK] = seven_s;                 // see (RULE15)
    id_word[4:2]           = TCIR_ID_DENSITY;         // see (RULE16)
    id_word[1:0]           = TCIR_ID_SPEED;           // see (RULE17)
  end

  assign level_word = {chan_num, int_level};          // see (RULE10) (RULE12)

  ////////////////////////////////////////////////////////////////////////////
  // Response selection
  logic [15:0] next_data;
  logic        next_nak;

  always_comb begin
    next_nak  = 1'b0;
    next_data = TCIR_WORD_RST;
    case (cmd_func)
      TCIR_FC_RANGE:   next_data = range_reg;         // see (RULE1)
      TCIR_FC_ADDR:    next_data = mem_addr;          // see (RULE6)
      TCIR_FC_CFG_A:   next_data = cfg_a;             // see (RULE8)
      TCIR_FC_CFG_B:   next_data = cfg_b_word;        // see (RULE9)
      TCIR_FC_INT_LVL: next_data = level_word;        // see (RULE10)
      TCIR_FC_DEV_ID:  next_data = id_word;           // see (RULE13)
      TCIR_FC_TASK:    next_data = task_word;         // see (RULE18)
      TCIR_FC_STATUS1: next_data = status1_word;      // see (RULE19)
      default:         next_nak  = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Second-half read response
  tcir_state_e state;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= TCIR_IDLE;
    end else begin
      case (state)
        TCIR_IDLE: begin
          if (in_cmd && !bus_init) begin
            state <= TCIR_RESP;
          end
        end
        TCIR_RESP: begin
          if (!(in_cmd && !bus_init)) begin
            state <= TCIR_IDLE;
          end
        end
        default: state <= TCIR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rsp_data <= TCIR_WORD_RST;
      rsp_addr <= TCIR_WORD_RST;
      rsp_nak  <= 1'b0;
    end else if (in_cmd && !bus_init) begin
      rsp_data <= next_nak ? TCIR_WORD_RST : next_data;
      rsp_addr <= cmd_data;                           // see (RULE2)
      rsp_nak  <= next_nak;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= in_cmd && !bus_init;
    end
  end

endmodule
`default_nettype wire

// ### tb/tcir_cpu_model.sv
// Processor model: issues function-coded commands and collects answers
// Assumes callers step 1 ns after a clk_sys edge
`timescale 1ns/1ps
`default_nettype none
module tcir_cpu_model (
  input  wire logic        clk_sys,
  input  wire logic        rsp_valid,
  input  wire logic        rsp_nak,
  input  wire logic [15:0] rsp_data,
  input  wire logic [15:0] rsp_addr,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [5:0]       cmd_func,
  output logic [15:0]      cmd_data
);
  logic        got;
  logic        nak;
  logic [15:0] data;
  logic [15:0] addr;
  initial begin
    {cmd_valid, cmd_write, cmd_func, cmd_data} = '0;
  end
  // Held through the taking edge, answer captured just after it
  task automatic issue(input logic w, input logic [5:0] f, input logic [15:0] d);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_func  = f;
    cmd_data  = d;
    @(posedge clk_sys);
    #1;
    got  = rsp_valid;
    nak  = rsp_nak;
    data = rsp_data;
    addr = rsp_addr;
  endtask
  // Released bus shows inverted data
  task automatic idle();
    cmd_valid = 1'b0;
    cmd_data  = ~cmd_data;
    @(posedge clk_sys);
    #1;
  endtask
endmodule
`default_nettype wire

// ### tb/tcir_top_assertions.sv
// Checker: answer timing and word contents at the top ports
// Assumes bound into tcir_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module tcir_top_assertions
  import tcir_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        bus_init,
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic [5:0]  cmd_func,
  input wire logic [15:0] cmd_data,
  input wire logic [9:0]  chan_num,
  input wire logic        rsp_valid,
  input wire logic        rsp_nak,
  input wire logic [15:0] rsp_data,
  input wire logic [15:0] rsp_addr
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic take;
  logic known;
  assign take  = cmd_valid && !cmd_write && !bus_init;
  assign known = cmd_func inside {TCIR_FC_RANGE, TCIR_FC_ADDR, TCIR_FC_CFG_A, TCIR_FC_CFG_B,
                                  TCIR_FC_INT_LVL, TCIR_FC_DEV_ID, TCIR_FC_TASK, TCIR_FC_STATUS1};
  sequence lvl_take;
    take && cmd_func == TCIR_FC_INT_LVL;
  endsequence
  sequence init_then_lvl;
    bus_init ##1 lvl_take;
  endsequence
  sequence id_take;
    take && cmd_func == TCIR_FC_DEV_ID;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  AST_ANSWER: assert property (
    take |=> rsp_valid && rsp_addr == $past(cmd_data))
    else $error("answer or echo wrong");
  AST_QUIET: assert property (
    !take |=> !rsp_valid)
    else $error("answer without input command");
  AST_LEVEL_CHAN: assert property (
    lvl_take |=> rsp_data[15:6] == $past(chan_num))
    else $error("level word channel wrong");
  AST_LEVEL_INIT: assert property (
    init_then_lvl |=> rsp_data[5:0] == 6'h00)
    else $error("level not zero after init");
  AST_ID_WORD: assert property (id_take |=>
    rsp_data[15:8] == TCIR_ID_SUBSYS && rsp_data[7:6] == 2'h1 && rsp_data[4:0] == 5'h1B)
    else $error("identification word wrong");
  AST_CFGB_RSVD: assert property (take && cmd_func == TCIR_FC_CFG_B |=>
    rsp_data[15:12] == 4'h0 && rsp_data[8:0] == 9'h000)
    else $error("config B reserved bits set");
  AST_STAT_RSVD: assert property (take && cmd_func == TCIR_FC_STATUS1 |=>
    (rsp_data & 16'h3D7F) == 16'h0000)
    else $error("status reserved bits set");
  AST_NAK: assert property (take |=>
    rsp_nak == !$past(known) && (!rsp_nak || rsp_data == 16'h0000))
    else $error("refusal wrong");
endmodule
bind tcir_top tcir_top_assertions i_tcir_top_assertions (
  .clk_sys   (clk_sys),
  .rst_n     (rst_n),
  .bus_init  (bus_init),
  .cmd_valid (cmd_valid),
  .cmd_write (cmd_write),
  .cmd_func  (cmd_func),
  .cmd_data  (cmd_data),
  .chan_num  (chan_num),
  .rsp_valid (rsp_valid),
  .rsp_nak   (rsp_nak),
  .rsp_data  (rsp_data),
  .rsp_addr  (rsp_addr)
);
`default_nettype wire

// ### tb/tcir_top_tb.sv
// Bench: table of input reads, then hand-written corner cases
// Assumes the processor model drives the command bus, the bench the rest
`timescale 1ns/1ps
`default_nettype none
module tcir_top_tb
  import tcir_pkg::*;
;
  typedef struct {logic [5:0] f; logic [15:0] e;} tcir_row_s;
  localparam logic [9:0] CHAN = 10'h2A5;
  logic        clk_sys, rst_n, bus_init, cmd_valid, cmd_write, rsp_valid, rsp_nak;
  logic        eng_range_load, eng_read_done, eng_addr_load, eng_write_done, eng_task_load;
  logic        pin_online, pin_loaded, pin_rewinding, pin_bot, pin_formatter_ready;
  logic        pin_seven_track, formatter_reset, bus_address_inhibit;
  logic [5:0]  cmd_func;
  logic [9:0]  chan_num;
  logic [15:0] cmd_data, eng_range_value, eng_block_len, eng_addr_value, eng_task_value;
  logic [15:0] rsp_data, rsp_addr;
  int          bad_count, samples_checked, cycles;
  tcir_row_s   rows [8];
  tcir_top       i_tcir_top (.*);
  tcir_cpu_model i_tcir_cpu_model (.*);
  ////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [5:0] f, input logic [15:0] d, input logic [15:0] e);
    i_tcir_cpu_model.issue(1'b0, f, d);
    chk({14'h0000, i_tcir_cpu_model.got, i_tcir_cpu_model.nak}, 16'h0002);
    chk(i_tcir_cpu_model.addr, d);
    chk(i_tcir_cpu_model.data, e);
    i_tcir_cpu_model.idle();
  endtask
  task automatic wr(input logic [5:0] f, input logic [15:0] d);
    i_tcir_cpu_model.issue(1'b1, f, d);
    chk({15'h0000, i_tcir_cpu_model.got}, 16'h0000);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    // Type 01, nine-track, dual density, top speed
    rows = '{'{TCIR_FC_RANGE, 16'h0100}, '{TCIR_FC_ADDR, 16'h1234},
             '{TCIR_FC_CFG_A, 16'hBEEF}, '{TCIR_FC_CFG_B, 16'h0A00},
             '{TCIR_FC_INT_LVL, {CHAN, 6'h15}}, '{TCIR_FC_DEV_ID, {TCIR_ID_SUBSYS, 8'h5B}},
             '{TCIR_FC_TASK, 16'h0042}, '{TCIR_FC_STATUS1, 16'h8200}};
    {rst_n, bus_init, eng_range_load, eng_read_done, eng_addr_load} = '0;
    {eng_write_done, eng_task_load, pin_rewinding, pin_seven_track} = '0;
    {pin_online, pin_loaded, pin_bot, pin_formatter_ready} = 4'hF;
    {eng_range_value, eng_block_len, eng_addr_value, eng_task_value} = '0;
    chan_num = CHAN;
    repeat (4) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    step(3);
    {eng_range_load, eng_addr_load, eng_task_load} = 3'h7;
    eng_range_value = 16'h0100;
    eng_addr_value  = 16'h1234;
    eng_task_value  = 16'h0042;
    step(1);
    {eng_range_load, eng_addr_load, eng_task_load} = 3'h0;
    wr(TCIR_FC_OUT_CFGA, 16'hBEEF);
    wr(TCIR_FC_OUT_CFGB, 16'h0800);
    wr(TCIR_FC_OUT_INT, 16'h0015);
    i_tcir_cpu_model.idle();
    chk({14'h0000, bus_address_inhibit, formatter_reset}, 16'h0002);
    i_tcir_cpu_model.issue(1'b0, TCIR_FC_STATUS1, 16'h0000);
    i_tcir_cpu_model.idle();
    for (int i = 0; i < 8; i++) begin
      rd(rows[i].f, 16'(i), rows[i].e);
    end
    $display("test table finished");
    // Short, long and exact blocks
    for (int i = 0; i < 3; i++) begin
      eng_range_load  = 1'b1;
      eng_range_value = i == 0 ? 16'h0100 : 16'h0080;
      step(1);
      eng_range_load = 1'b0;
      eng_read_done  = 1'b1;
      eng_block_len  = i == 0 ? 16'h0040 : (i == 1 ? 16'h0090 : 16'h0080);
      step(1);
      eng_read_done = 1'b0;
      rd(TCIR_FC_RANGE, 16'h5A5A, i == 0 ? 16'h00C0 : 16'h0000);
      rd(TCIR_FC_STATUS1, 16'hA5A5, i == 2 ? 16'h8200 : 16'h8280);
    end
    for (int i = 0; i < 2; i++) begin
      eng_write_done = 1'b1;
      eng_addr_value = 16'h2003 + 16'(i);
      step(1);
      eng_write_done = 1'b0;
      rd(TCIR_FC_ADDR, 16'h0F0F, 16'h2004);
    end
    pin_rewinding = 1'b1;
    step(4);
    rd(TCIR_FC_STATUS1, 16'h1234, 16'h4200);
    $display("test residual finished");
    i_tcir_cpu_model.issue(1'b0, TCIR_FC_TASK, 16'h1111);
    chk(i_tcir_cpu_model.data, 16'h0042);
    i_tcir_cpu_model.issue(1'b0, 6'h3F, 16'h2222);
    chk({15'h0000, i_tcir_cpu_model.nak}, 16'h0001);
    chk(i_tcir_cpu_model.data, 16'h0000);
    bus_init = 1'b1;
    i_tcir_cpu_model.issue(1'b0, TCIR_FC_INT_LVL, 16'h3333);
    bus_init = 1'b0;
    chk({15'h0000, i_tcir_cpu_model.got}, 16'h0000);
    rd(TCIR_FC_INT_LVL, 16'h4444, {CHAN, 6'h00});
    rd(TCIR_FC_TASK, 16'h5555, 16'h0000);
    rd(TCIR_FC_RANGE, 16'h6666, 16'h0000);
    // Seven-track drives
    pin_seven_track = 1'b1;
    step(3);
    rd(TCIR_FC_DEV_ID, 16'h8888, {TCIR_ID_SUBSYS, 8'h7B});
    $display("test corners finished");
    // Formatter controls, then a reset in mid-run
    wr(TCIR_FC_OUT_CFGB, 16'h0C00);
    i_tcir_cpu_model.idle();
    chk({14'h0000, bus_address_inhibit, formatter_reset}, 16'h0003);
    rst_n = 1'b0;
    step(1);
    chk({14'h0000, bus_address_inhibit, formatter_reset}, 16'h0000);
    chk(rsp_data, 16'h0000);
    rst_n = 1'b1;
    step(3);
    rd(TCIR_FC_CFG_B, 16'h7777, 16'h0200);
    $display("test reset finished");
    conclude();
  end
endmodule
`default_nettype wire
